// file: verilog/bbc_calendar_clock.sv
// Decided for this implementation: the address map and the Wishbone interface to the registers.
`timescale 1ns/1ps
module bbc_calendar_clock
    import bbc_pkg::*;
#(
    parameter int unsigned TICKS_PER_SEC = TICKS_PER_SECOND
) (
    input  logic             ref_clk,
    input  logic             rst,
    input  logic             wb_cyc_i,
    input  logic             wb_stb_i,
    input  logic             wb_we_i,
    input  logic [ADR_W-1:0] wb_adr_i,
    input  logic [DAT_W-1:0] wb_dat_i,
    input  logic [SEL_W-1:0] wb_sel_i,
    output logic [DAT_W-1:0] wb_dat_o,
    output logic             wb_ack_o,
    input  logic             stop_to_stopped,
    input  logic             stop_sw_fault,
    input  logic             stop_power_break,
    input  logic             stop_hw_fault,
    input  logic             stop_halt
);
    // ========================================================
    // Elaboration check
    if (TICKS_PER_SEC < 2) begin : g_bad_ticks
        $error("TICKS_PER_SEC must be at least 2");
    end

    // ========================================================
    // State
    logic [7:0]       fld      [NUM_FIELDS];
    logic [7:0]       next_fld [NUM_FIELDS];
    logic [7:0]       stop_fld [NUM_FIELDS];
    logic [7:0]       stop_cause;
    logic [15:0]      adjust;
    logic [15:0]      next_adjust;
    logic             write_mode;
    logic             adj_en;
    logic [31:0]      sec_cnt;
    logic [3:0]       adj_bit;
    logic [DAT_W-1:0] rd_word;

    // ========================================================
    // Bus decode
    // Writes land on the edge where ack is seen, as the master expects.
    wire acc      = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire take     = wb_cyc_i & wb_stb_i & wb_ack_o;
    wire wr_take  = take & wb_we_i;
    wire hit_time = (wb_adr_i == ADR_WDAY) | (wb_adr_i == ADR_SEC) |
                    (wb_adr_i == ADR_HM) | (wb_adr_i == ADR_MD) |
                    (wb_adr_i == ADR_CY);
    wire wr_time  = wr_take & write_mode & hit_time;
    wire wr_adj   = wr_take & (wb_adr_i == ADR_ADJ);
    wire wr_ctrl  = wr_take & (wb_adr_i == ADR_CTRL) & wb_sel_i[0];
    wire wr_secw  = wr_time & (wb_adr_i == ADR_SEC);

    // ========================================================
    // Second base and calendar
    // Runs from the backed-up clock alone; main power is not looked at.
    wire       tick = (sec_cnt == TICKS_PER_SEC - 1);
    wire [7:0] dim  = month_days(fld[F_MON], fld[F_YEAR], fld[F_CENT]);

    // Lowest pending adjust bit is served first, one field per cycle.
    always_comb begin
        adj_bit = 4'h0;
        for (int i = 15; i >= 0; i--) begin
            if (adjust[i])
                adj_bit = 4'(i);
        end
    end

    wire       adj_go   = adj_en & (|adjust) & ~wr_time;
    wire [2:0] adj_fld  = adj_bit[2:0];
    wire       adj_down = adj_bit[3];
    wire [7:0] adj_lo   = field_lo(int'(adj_fld));
    wire [7:0] adj_hi   = field_hi(int'(adj_fld), dim);

    // A second that falls on a write or an adjust step is dropped;
    // that keeps the three update paths from fighting over a field.
    always_comb begin
        logic       cy;
        logic [7:0] v;
        cy = 1'b1;
        v  = BCD_ZERO;
        for (int i = 0; i < NUM_FIELDS; i++)
            next_fld[i] = fld[i];
        if (wr_time) begin
            for (int i = 0; i < NUM_FIELDS; i++) begin
                v = field_high(i) ? wb_dat_i[15:8] : wb_dat_i[7:0];
                if (wb_adr_i == field_adr(i) &&
                    wb_sel_i[field_high(i)] &&
                    bcd_ok(v, field_lo(i), field_hi(i, DAY_MAX)))
                    next_fld[i] = v;
            end
        end else if (adj_go) begin
            if (adj_down)
                next_fld[adj_fld] = bcd_dec(fld[adj_fld],
                                            adj_lo, adj_hi);
            else
                next_fld[adj_fld] = bcd_inc(fld[adj_fld],
                                            adj_lo, adj_hi);
        end else if (tick) begin
            // Plain carry chain; the hour never shifts for seasons.
            for (int i = F_SEC; i <= F_CENT; i++) begin
                if (cy) begin
                    next_fld[i] = bcd_inc(fld[i], field_lo(i),
                                          field_hi(i, dim));
                    cy = fld[i] >= field_hi(i, dim);
                    if (i == F_HOUR && cy)
                        next_fld[F_WDAY] = bcd_inc(fld[F_WDAY],
                                                   WDAY_MIN, WDAY_MAX);
                end
            end
        end
    end

    always_comb begin
        next_adjust = adjust;
        if (adj_go)
            next_adjust[adj_bit] = 1'b0;
        if (wr_adj && wb_sel_i[0])
            next_adjust[7:0] = wb_dat_i[7:0];
        if (wr_adj && wb_sel_i[1])
            next_adjust[15:8] = wb_dat_i[15:8];
    end

    // ========================================================
    // Stop record
    wire       stop_any = stop_to_stopped | stop_sw_fault |
                          stop_power_break | stop_hw_fault | stop_halt;
    wire [7:0] cause    = stop_hw_fault    ? CAUSE_HW   :
                          stop_power_break ? CAUSE_PWR  :
                          stop_sw_fault    ? CAUSE_SW   :
                          stop_halt        ? CAUSE_HALT :
                                             CAUSE_STOP;

    // ========================================================
    // Read mux
    assign rd_word =
        (wb_adr_i == ADR_WDAY)  ? {PAD16, BCD_ZERO, fld[F_WDAY]} :
        (wb_adr_i == ADR_SEC)   ? {PAD16, fld[F_SEC], BCD_ZERO} :
        (wb_adr_i == ADR_HM)    ? {PAD16, fld[F_HOUR], fld[F_MIN]} :
        (wb_adr_i == ADR_MD)    ? {PAD16, fld[F_MON], fld[F_DAY]} :
        (wb_adr_i == ADR_CY)    ? {PAD16, fld[F_CENT], fld[F_YEAR]} :
        (wb_adr_i == ADR_ADJ)   ? {PAD16, adjust} :
        (wb_adr_i == ADR_CTRL)  ? {PAD30, adj_en, write_mode} :
        (wb_adr_i == ADR_S_SEC) ? {PAD16, stop_fld[F_SEC], BCD_ZERO} :
        (wb_adr_i == ADR_S_HM)  ? {PAD16, stop_fld[F_HOUR],
                                   stop_fld[F_MIN]} :
        (wb_adr_i == ADR_S_MD)  ? {PAD16, stop_fld[F_MON],
                                   stop_fld[F_DAY]} :
        (wb_adr_i == ADR_S_CY)  ? {PAD16, stop_fld[F_CENT],
                                   stop_fld[F_YEAR]} :
        (wb_adr_i == ADR_S_WC)  ? {PAD16, stop_fld[F_WDAY],
                                   stop_cause} :
        {PAD16, PAD16};

    // ========================================================
    // Registers
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= {PAD16, PAD16};
        end else begin
            wb_ack_o <= acc;
            if (acc)
                wb_dat_o <= rd_word;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst || tick || wr_secw)
            sec_cnt <= 32'h00000000;
        else
            sec_cnt <= sec_cnt + 32'h00000001;
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            for (int i = 0; i < NUM_FIELDS; i++)
                fld[i] <= field_lo(i);
        end else begin
            fld <= next_fld;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            for (int i = 0; i < NUM_FIELDS; i++)
                stop_fld[i] <= BCD_ZERO;
            stop_cause <= CAUSE_NONE;
        end else if (stop_any) begin
            stop_fld   <= fld;
            stop_cause <= cause;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            adjust     <= PAD16;
            write_mode <= 1'b0;
            adj_en     <= 1'b0;
        end else begin
            adjust <= next_adjust;
            if (wr_ctrl) begin
                write_mode <= wb_dat_i[CTRL_WRITE];
                adj_en     <= wb_dat_i[CTRL_ADJ];
            end
        end
    end

    // ========================================================
    // Checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    chk_sec_range: assert property (
        bcd_ok(fld[F_SEC], BCD_ZERO, MS_MAX) &&
        bcd_ok(fld[F_WDAY], WDAY_MIN, WDAY_MAX))
        else $error("seconds or weekday out of range");

    chk_day_range: assert property (
        bcd_ok(fld[F_HOUR], BCD_ZERO, HOUR_MAX) &&
        bcd_ok(fld[F_DAY], DAY_MIN, DAY_MAX) &&
        bcd_ok(fld[F_MON], MON_MIN, MON_MAX))
        else $error("hour, day or month out of range");

    chk_tick_sec: assert property (
        tick && !wr_time && !adj_go |=>
        fld[F_SEC] == bcd_inc($past(fld[F_SEC]), BCD_ZERO, MS_MAX))
        else $error("second did not advance on tick");

    chk_ro_mode: assert property (
        wr_take && !write_mode && wb_adr_i == ADR_HM &&
        !adj_go && !tick |=> $stable(fld[F_MIN]) && $stable(fld[F_HOUR]))
        else $error("time word changed with write mode clear");

    chk_write_load: assert property (
        wr_time && wb_adr_i == ADR_SEC && wb_sel_i[1] &&
        bcd_ok(wb_dat_i[15:8], BCD_ZERO, MS_MAX) |=>
        fld[F_SEC] == $past(wb_dat_i[15:8]))
        else $error("seconds write not loaded");

    chk_adj_clear: assert property (
        adj_go && !wr_adj |=> !adjust[$past(adj_bit)])
        else $error("served adjust bit not cleared");

    chk_adj_inc: assert property (
        adj_go && !adj_down && adj_fld == 3'(F_MIN) |=>
        fld[F_MIN] == bcd_inc($past(fld[F_MIN]), BCD_ZERO, MS_MAX) &&
        $stable(fld[F_HOUR]))
        else $error("minute increment wrong");

    chk_adj_dec: assert property (
        adj_go && adj_down && adj_fld == 3'(F_HOUR) |=>
        fld[F_HOUR] == bcd_dec($past(fld[F_HOUR]), BCD_ZERO, HOUR_MAX))
        else $error("hour decrement wrong");

    chk_stop_capture: assert property (
        stop_any |=> stop_fld[F_SEC] == $past(fld[F_SEC]) &&
        stop_fld[F_WDAY] == $past(fld[F_WDAY]))
        else $error("stop time not captured");

    chk_cause_code: assert property (
        stop_power_break && !stop_hw_fault ##1 !stop_any [*2] |->
        stop_cause == CAUSE_PWR)
        else $error("power break cause not four");

    chk_stop_read: assert property (
        acc && wb_adr_i == ADR_S_WC && !stop_any |=>
        wb_ack_o && wb_dat_o[7:0] == stop_cause)
        else $error("stop cause read wrong");

    cov_min_roll: cover property (tick && fld[F_SEC] == MS_MAX);
    cov_adjust:   cover property (adj_go ##1 adj_go);
    cov_stop:     cover property (stop_any);
    cov_load:     cover property (wr_time);
endmodule

// file: include/bbc_pkg.sv
// Operation
// - Keep date and time in five BCD words.
// - Weekday low byte 1-7, seconds high 0-59.
// - Pack hour/min, month/day, century/year words.
// - Mode clear: time words read-only, show running time.
// - Mode set: written time words load at once.
// - Adjust enable: step fields from present value.
// - Adjust bits 0-7 increment fields in order.
// - Adjust bits 8-15 decrement fields in order.
// - No automatic daylight-saving hour shift.
// - Keep counting while main power is off.
// - Capture stop date and time at stop.
// - Stop words packed, weekday high cause low.
// - Stop cause readable as BCD low byte.
// - Cause codes 1,2,4,5,6 per stop reason.
package bbc_pkg;
    // ========================================================
    // Bus layout
    localparam int         ADR_W    = 8;
    localparam int         DAT_W    = 32;
    localparam int         SEL_W    = 4;
    localparam logic [7:0] ADR_WDAY = 8'h00;
    localparam logic [7:0] ADR_SEC  = 8'h04;
    localparam logic [7:0] ADR_HM   = 8'h08;
    localparam logic [7:0] ADR_MD   = 8'h0C;
    localparam logic [7:0] ADR_CY   = 8'h10;
    localparam logic [7:0] ADR_ADJ  = 8'h14;
    localparam logic [7:0] ADR_CTRL = 8'h18;
    localparam logic [7:0] ADR_S_SEC = 8'h20;
    localparam logic [7:0] ADR_S_HM = 8'h24;
    localparam logic [7:0] ADR_S_MD = 8'h28;
    localparam logic [7:0] ADR_S_CY = 8'h2C;
    localparam logic [7:0] ADR_S_WC = 8'h30;
    localparam int         CTRL_WRITE = 0;
    localparam int         CTRL_ADJ   = 1;
    localparam logic [15:0] PAD16   = 16'h0000;
    localparam logic [29:0] PAD30   = 30'h00000000;
    // ========================================================
    // Field indexes, in adjust bit order
    localparam int NUM_FIELDS = 8;
    localparam int F_WDAY = 0;
    localparam int F_SEC  = 1;
    localparam int F_MIN  = 2;
    localparam int F_HOUR = 3;
    localparam int F_DAY  = 4;
    localparam int F_MON  = 5;
    localparam int F_YEAR = 6;
    localparam int F_CENT = 7;
    // ========================================================
    // BCD limits and calendar values
    localparam logic [7:0] BCD_ZERO  = 8'h00;
    localparam logic [7:0] WDAY_MIN  = 8'h01;
    localparam logic [7:0] WDAY_MAX  = 8'h07;
    localparam logic [7:0] MS_MAX    = 8'h59;
    localparam logic [7:0] HOUR_MAX  = 8'h23;
    localparam logic [7:0] DAY_MIN   = 8'h01;
    localparam logic [7:0] DAY_MAX   = 8'h31;
    localparam logic [7:0] DAY_SHORT = 8'h30;
    localparam logic [7:0] DAY_FEB   = 8'h28;
    localparam logic [7:0] DAY_LEAP  = 8'h29;
    localparam logic [7:0] MON_MIN   = 8'h01;
    localparam logic [7:0] MON_MAX   = 8'h12;
    localparam logic [7:0] MON_FEB   = 8'h02;
    localparam logic [7:0] MON_APR   = 8'h04;
    localparam logic [7:0] MON_JUN   = 8'h06;
    localparam logic [7:0] MON_SEP   = 8'h09;
    localparam logic [7:0] MON_NOV   = 8'h11;
    localparam logic [7:0] YC_MAX    = 8'h99;
    localparam logic [3:0] NIB_ZERO  = 4'h0;
    localparam logic [3:0] NIB_ONE   = 4'h1;
    localparam logic [3:0] NIB_NINE  = 4'h9;
    localparam logic [6:0] TEN       = 7'h0A;
    localparam logic [1:0] LEAP_MOD  = 2'h0;
    // ========================================================
    // Stop causes, BCD
    localparam logic [7:0] CAUSE_NONE = 8'h00;
    localparam logic [7:0] CAUSE_STOP = 8'h01;
    localparam logic [7:0] CAUSE_SW   = 8'h02;
    localparam logic [7:0] CAUSE_PWR  = 8'h04;
    localparam logic [7:0] CAUSE_HW   = 8'h05;
    localparam logic [7:0] CAUSE_HALT = 8'h06;
    // ========================================================
    // Timing
    localparam int unsigned SECOND_NS     = 1_000_000_000;
    localparam int unsigned CLK_PERIOD_NS = 100;
    localparam int unsigned TICKS_PER_SECOND = SECOND_NS / CLK_PERIOD_NS;
    // ========================================================
    // BCD helpers
    function automatic logic [7:0] bcd_inc(input logic [7:0] v,
                                           input logic [7:0] lo,
                                           input logic [7:0] hi);
        if (v >= hi)
            return lo;
        if (v[3:0] == NIB_NINE)
            return {v[7:4] + NIB_ONE, NIB_ZERO};
        return {v[7:4], v[3:0] + NIB_ONE};
    endfunction

    function automatic logic [7:0] bcd_dec(input logic [7:0] v,
                                           input logic [7:0] lo,
                                           input logic [7:0] hi);
        if (v <= lo)
            return hi;
        if (v[3:0] == NIB_ZERO)
            return {v[7:4] - NIB_ONE, NIB_NINE};
        return {v[7:4], v[3:0] - NIB_ONE};
    endfunction

    function automatic logic bcd_ok(input logic [7:0] v,
                                    input logic [7:0] lo,
                                    input logic [7:0] hi);
        return (v[3:0] <= NIB_NINE) && (v[7:4] <= NIB_NINE) &&
               (v >= lo) && (v <= hi);
    endfunction

    function automatic logic [6:0] bcd_bin(input logic [7:0] v);
        return 7'(v[7:4]) * TEN + 7'(v[3:0]);
    endfunction

    function automatic logic [7:0] month_days(input logic [7:0] mon,
                                              input logic [7:0] year,
                                              input logic [7:0] cent);
        logic [6:0] y;
        logic [6:0] c;
        logic       leap;
        y = bcd_bin(year);
        c = bcd_bin(cent);
        leap = (year == BCD_ZERO) ? (c[1:0] == LEAP_MOD)
                                  : (y[1:0] == LEAP_MOD);
        if (mon == MON_FEB)
            return leap ? DAY_LEAP : DAY_FEB;
        if (mon == MON_APR || mon == MON_JUN ||
            mon == MON_SEP || mon == MON_NOV)
            return DAY_SHORT;
        return DAY_MAX;
    endfunction

    function automatic logic [7:0] field_lo(input int i);
        case (i)
            F_WDAY:  return WDAY_MIN;
            F_DAY:   return DAY_MIN;
            F_MON:   return MON_MIN;
            default: return BCD_ZERO;
        endcase
    endfunction

    function automatic logic [7:0] field_hi(input int i,
                                            input logic [7:0] dmax);
        case (i)
            F_WDAY:       return WDAY_MAX;
            F_SEC, F_MIN: return MS_MAX;
            F_HOUR:       return HOUR_MAX;
            F_DAY:        return dmax;
            F_MON:        return MON_MAX;
            default:      return YC_MAX;
        endcase
    endfunction

    function automatic logic [7:0] field_adr(input int i);
        case (i)
            F_WDAY:        return ADR_WDAY;
            F_SEC:         return ADR_SEC;
            F_MIN, F_HOUR: return ADR_HM;
            F_DAY, F_MON:  return ADR_MD;
            default:       return ADR_CY;
        endcase
    endfunction

    function automatic logic field_high(input int i);
        return (i == F_SEC) || (i == F_HOUR) ||
               (i == F_MON) || (i == F_CENT);
    endfunction
endpackage

// file: sim/tb.sv
`timescale 1ns/1ps
module tb;
    import bbc_pkg::*;
    // ========================================================
    // Bench set-up
    // A short second keeps the rollover scenario cheap to run.
    localparam int unsigned TPS = 200;
    logic             ref_clk = 1'b0;
    logic             rst     = 1'b1;
    logic             wb_cyc  = 1'b0;
    logic             wb_stb  = 1'b0;
    logic             wb_we   = 1'b0;
    logic [ADR_W-1:0] wb_adr  = 8'h00;
    logic [DAT_W-1:0] wb_dat  = 32'h00000000;
    logic [SEL_W-1:0] wb_sel  = 4'h0;
    logic [DAT_W-1:0] wb_rdat;
    logic             wb_ack;
    logic [4:0]       stop_v  = 5'h00;
    logic [15:0]      q;
    int               err_total = 0;
    int               checks    = 0;
    int               f [8];
    int               lo_v [8]  = '{1, 0, 0, 0, 1, 1, 0, 0};
    int               hi_v [8]  = '{7, 59, 59, 23, 31, 12, 99, 99};
    logic [7:0]       cause_v [5] = '{8'h01, 8'h02, 8'h04, 8'h05, 8'h06};

    always #50 ref_clk = ~ref_clk;

    bbc_calendar_clock #(.TICKS_PER_SEC(TPS)) bbc_calendar_clock_i (
        .ref_clk          (ref_clk),
        .rst              (rst),
        .wb_cyc_i         (wb_cyc),
        .wb_stb_i         (wb_stb),
        .wb_we_i          (wb_we),
        .wb_adr_i         (wb_adr),
        .wb_dat_i         (wb_dat),
        .wb_sel_i         (wb_sel),
        .wb_dat_o         (wb_rdat),
        .wb_ack_o         (wb_ack),
        .stop_to_stopped  (stop_v[0]),
        .stop_sw_fault    (stop_v[1]),
        .stop_power_break (stop_v[2]),
        .stop_hw_fault    (stop_v[3]),
        .stop_halt        (stop_v[4])
    );

    // ========================================================
    // Tasks
    function automatic logic [7:0] bcd(input int v);
        return 8'((v / 10) * 16 + v % 10);
    endfunction

    task automatic report_and_stop();
        if (err_total == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch at %0t: got %h want %h", $time, seen, exp);
        end
    endtask

    // Called just after a rising edge; holds the request until ack.
    task automatic wb(input logic we, input logic [7:0] a,
                      input logic [15:0] d);
        int n;
        n = 0;
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we  <= we;
        wb_adr <= a;
        wb_sel <= 4'h3;
        wb_dat <= {PAD16, d};
        do begin
            @(posedge ref_clk);
            n++;
        end while (wb_ack !== 1'b1 && n < 50);
        if (wb_ack !== 1'b1) begin
            err_total++;
            $display("mismatch at %0t: no ack", $time);
        end
        q = wb_rdat[15:0];
        if (!we)
            chk(wb_rdat[31:16], 16'h0000);
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        @(posedge ref_clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        wb(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a);
        wb(1'b0, a, 16'h0000);
    endtask

    task automatic check_live();
        rd(ADR_WDAY);
        chk(q, {8'h00, bcd(f[F_WDAY])});
        rd(ADR_SEC);
        chk(q, {bcd(f[F_SEC]), 8'h00});
        rd(ADR_HM);
        chk(q, {bcd(f[F_HOUR]), bcd(f[F_MIN])});
        rd(ADR_MD);
        chk(q, {bcd(f[F_MON]), bcd(f[F_DAY])});
        rd(ADR_CY);
        chk(q, {bcd(f[F_CENT]), bcd(f[F_YEAR])});
    endtask

    // Seconds go last, since that write restarts the second counter.
    task automatic load_time();
        wr(ADR_CTRL, 16'h0001);
        wr(ADR_WDAY, {8'h00, bcd(f[F_WDAY])});
        wr(ADR_HM, {bcd(f[F_HOUR]), bcd(f[F_MIN])});
        wr(ADR_MD, {bcd(f[F_MON]), bcd(f[F_DAY])});
        wr(ADR_CY, {bcd(f[F_CENT]), bcd(f[F_YEAR])});
        wr(ADR_SEC, {bcd(f[F_SEC]), 8'h00});
    endtask

    task automatic capture_check(input int c);
        stop_v <= 5'(1 << c);
        @(posedge ref_clk);
        stop_v <= 5'h00;
        @(posedge ref_clk);
        wr(ADR_S_SEC, 16'hFFFF);
        rd(ADR_S_SEC);
        chk(q, {bcd(f[F_SEC]), 8'h00});
        rd(ADR_S_HM);
        chk(q, {bcd(f[F_HOUR]), bcd(f[F_MIN])});
        rd(ADR_S_MD);
        chk(q, {bcd(f[F_MON]), bcd(f[F_DAY])});
        rd(ADR_S_CY);
        chk(q, {bcd(f[F_CENT]), bcd(f[F_YEAR])});
        rd(ADR_S_WC);
        chk(q, {bcd(f[F_WDAY]), cause_v[c]});
    endtask

    // ========================================================
    // Watchdog
    initial begin
        repeat (20000) @(posedge ref_clk);
        err_total++;
        report_and_stop();
    end

    // ========================================================
    // Scenarios
    initial begin
        void'($urandom(7095));
        repeat (6) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        f = lo_v;
        check_live();
        rd(ADR_ADJ);
        chk(q, 16'h0000);
        for (int a = 32; a <= 60; a += 4) begin
            rd(8'(a));
            chk(q, 16'h0000);
        end
        f[F_WDAY] = 1 + int'($urandom % 7);
        f[F_SEC]  = int'($urandom % 60);
        f[F_MIN]  = int'($urandom % 60);
        f[F_HOUR] = int'($urandom % 24);
        f[F_DAY]  = 1 + int'($urandom % 28);
        f[F_MON]  = 1 + int'($urandom % 12);
        f[F_YEAR] = int'($urandom % 100);
        f[F_CENT] = int'($urandom % 100);
        load_time();
        wr(ADR_SEC, 16'h6A00);
        wr(ADR_HM, 16'h2460);
        check_live();
        wr(ADR_CTRL, 16'h0000);
        wr(ADR_HM, {bcd((f[F_HOUR] + 1) % 24), bcd(f[F_MIN])});
        check_live();
        f = '{7, 59, 59, 23, 31, 12, 99, 20};
        load_time();
        wr(ADR_CTRL, 16'h0000);
        repeat (20) @(posedge ref_clk);
        capture_check(0);
        f = '{1, 0, 0, 0, 1, 1, 0, 21};
        repeat (TPS) @(posedge ref_clk);
        capture_check(1);
        for (int k = 0; k < 16; k++) begin
            if (k < 8) begin
                f = hi_v;
            end else begin
                f = lo_v;
            end
            load_time();
            wr(ADR_CTRL, 16'h0002);
            rd(ADR_CTRL);
            chk(q, 16'h0002);
            wr(ADR_ADJ, 16'(1 << k));
            repeat (2) @(posedge ref_clk);
            rd(ADR_ADJ);
            chk(q, 16'h0000);
            if (k < 8) begin
                f[k] = lo_v[k];
            end else begin
                f[k - 8] = hi_v[k - 8];
            end
            capture_check(k % 5);
        end
        // Two pending bits are served on two cycles, lowest first.
        wr(ADR_ADJ, 16'h0006);
        repeat (3) @(posedge ref_clk);
        f[F_SEC] = 1;
        f[F_MIN] = 1;
        capture_check(3);
        report_and_stop();
    end
endmodule
